// ==== logic/pelt_defs.vh ====
// Register offsets, field positions and reset values of the PCI error log and target image block.
`ifndef PELT_DEFS_VH
`define PELT_DEFS_VH

`define PELT_CMD_LOG_OFF      12'h18C
`define PELT_ADDR_LOG_OFF     12'h190
`define PELT_IMG_CTL_OFF      12'h1A0
`define PELT_IMG_BASE_OFF     12'h1A4
`define PELT_IMG_BOUND_OFF    12'h1A8
`define PELT_IMG_XLAT_OFF     12'h1AC

`define PELT_CMD_LSB          28
`define PELT_MULTI_BIT        27
`define PELT_VALID_BIT        23
`define PELT_CMD_RESET        4'h7

`define PELT_EN_BIT           31
`define PELT_POSTED_BIT       30
`define PELT_WIDTH_LSB        22
`define PELT_SPACE_LSB        16
`define PELT_PROGRAM_BIT      14
`define PELT_SUPER_BIT        12
`define PELT_CYCLE_BIT        8
`define PELT_IOSPACE_BIT      0
`define PELT_WIDTH_RESET      2'h2

`define PELT_WIDTH_64         2'h3
`define PELT_SPACE_A24        3'h1
`define PELT_SPACE_A32        3'h2
`define PELT_SPACE_RSV_LO     3'h3
`define PELT_SPACE_RSV_HI     3'h4

`define PELT_PAGE_LSB         12

`endif

// ==== logic/pelt_error_log.v ====
// Freezing capture of the failing posted write's command and start address.
`timescale 1ns/1ps
`default_nettype none
`include "pelt_defs.vh"

module pelt_error_log #(
	parameter CMD_W  = 4,
	parameter ADDR_W = 32
) (
	input  wire              clk,
	input  wire              reset,
	input  wire              err_event,
	input  wire [CMD_W-1:0]  err_command,
	input  wire [ADDR_W-1:0] err_address,
	input  wire              rearm,
	output reg               log_valid,
	output reg               multi_error,
	output reg  [CMD_W-1:0]  cmd_log,
	output reg  [ADDR_W-1:0] addr_log
);

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			log_valid   <= 1'b0;
			multi_error <= 1'b0;
			cmd_log     <= `PELT_CMD_RESET;
			addr_log    <= {ADDR_W{1'b0}};
		end else begin
			if (err_event && !log_valid) begin
				// A fresh capture wins over a rearm in the same cycle.
				log_valid   <= 1'b1;
				multi_error <= 1'b0;
				cmd_log     <= err_command;
				addr_log    <= err_address;
			end else if (err_event && log_valid) begin
				multi_error <= 1'b1;
				if (rearm) begin
					log_valid <= 1'b0;
				end
			end else if (rearm) begin
				log_valid <= 1'b0;
			end
		end
	end

endmodule // pelt_error_log
`default_nettype wire

// ==== logic/pelt_top.v ====
// PCI-side error log registers and target image four control with its decoder.
// Register map: 0x18C command log, 0x190 address log, 0x1A0 image control,
// 0x1A4 image base, 0x1A8 image bound and 0x1AC translation offset.
// Command log: failed command in 31:28, multiple error in 27, log valid in 23.
// Address log: the full start address of the failing posted write.
// Image control: enable 31, posted write 30, data width 23:22, address space 18:16,
// program 14, supervisor 12, cycle type 8 and I/O space 0.
// Base, bound and translation offset hold a 4 KB page number in bits 31:12.
// Read data stand only in the cycle after the read strobe and read zero otherwise.
// Reserved and unmapped bits read as zero, and writes to them are dropped.
`timescale 1ns/1ps
`default_nettype none
`include "pelt_defs.vh"

module pelt_top #(
	parameter ADDR_W = 12
) (
	input  wire              clk,
	input  wire              reset,
	input  wire [ADDR_W-1:0] reg_addr,
	input  wire [31:0]       reg_wdata,
	input  wire              reg_write,
	input  wire              reg_read,
	output reg  [31:0]       reg_rdata,
	input  wire              pw_target_abort,
	input  wire              pw_master_abort,
	input  wire              pw_retry_expired,
	input  wire [3:0]        pw_command,
	input  wire [31:0]       pw_start_address,
	input  wire              pci_access,
	input  wire              pci_io_access,
	input  wire [31:0]       pci_address,
	output wire              image_hit,
	output wire              image_posted_write,
	output wire [1:0]        vme_max_data_width,
	output wire [2:0]        vme_address_space,
	output wire              program_data_select,
	output wire              supervisor_select,
	output wire              vme_block_transfer,
	output wire              vme_mblt_allowed,
	output wire              vme_space_reserved,
	output wire [31:0]       vme_address
);

	// Fields of the image four control register.
	reg        image_enable;
	reg        posted_write_enable;
	reg  [1:0] width_sel;
	reg  [2:0] space_sel;
	reg        program_sel;
	reg        supervisor_sel;
	reg        vme_cycle_type;
	reg        pci_space_select;

	// Page numbers of the image window and of its translation.
	reg [19:0] image_base;
	reg [19:0] image_bound;
	reg [19:0] image_translation_offset;

	// Write strobes decoded once per register.
	wire       wr_cmd_log;
	wire       wr_ctl;
	wire       wr_base;
	wire       wr_bound;
	wire       wr_xlat;

	wire        log_valid;
	wire        multi_error;
	wire  [3:0] cmd_log;
	wire [31:0] addr_log;
	wire        err_event;
	wire        rearm;
	reg  [31:0] next_rdata;

	assign err_event = pw_target_abort | pw_master_abort | pw_retry_expired;
	assign wr_cmd_log = reg_write && (reg_addr == `PELT_CMD_LOG_OFF);
	assign wr_ctl     = reg_write && (reg_addr == `PELT_IMG_CTL_OFF);
	assign wr_base    = reg_write && (reg_addr == `PELT_IMG_BASE_OFF);
	assign wr_bound   = reg_write && (reg_addr == `PELT_IMG_BOUND_OFF);
	assign wr_xlat    = reg_write && (reg_addr == `PELT_IMG_XLAT_OFF);
	// Only a one in the valid bit rearms capture; a zero there is ignored.
	assign rearm      = wr_cmd_log && reg_wdata[`PELT_VALID_BIT];

	pelt_error_log #(
		.CMD_W  (4),
		.ADDR_W (32)
	) u_log (
		.clk         (clk),
		.reset       (reset),
		.err_event   (err_event),
		.err_command (pw_command),
		.err_address (pw_start_address),
		.rearm       (rearm),
		.log_valid   (log_valid),
		.multi_error (multi_error),
		.cmd_log     (cmd_log),
		.addr_log    (addr_log)
	);

	// Control fields, one process each; reset clears them, except the data width, which it loads with 2'h2.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			image_enable <= 1'b0;
		end else if (wr_ctl) begin
			image_enable <= reg_wdata[`PELT_EN_BIT];
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			posted_write_enable <= 1'b0;
		end else if (wr_ctl) begin
			posted_write_enable <= reg_wdata[`PELT_POSTED_BIT];
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			width_sel <= `PELT_WIDTH_RESET;
		end else if (wr_ctl) begin
			width_sel <= reg_wdata[`PELT_WIDTH_LSB +: 2];
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			space_sel <= 3'h0;
		end else if (wr_ctl) begin
			space_sel <= reg_wdata[`PELT_SPACE_LSB +: 3];
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			program_sel <= 1'b0;
		end else if (wr_ctl) begin
			program_sel <= reg_wdata[`PELT_PROGRAM_BIT];
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			supervisor_sel <= 1'b0;
		end else if (wr_ctl) begin
			supervisor_sel <= reg_wdata[`PELT_SUPER_BIT];
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			vme_cycle_type <= 1'b0;
		end else if (wr_ctl) begin
			vme_cycle_type <= reg_wdata[`PELT_CYCLE_BIT];
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			pci_space_select <= 1'b0;
		end else if (wr_ctl) begin
			pci_space_select <= reg_wdata[`PELT_IOSPACE_BIT];
		end
	end

	// Window and translation pages; the low twelve bits are not stored.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			image_base <= 20'h00000;
		end else if (wr_base) begin
			image_base <= reg_wdata[31:`PELT_PAGE_LSB];
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			image_bound <= 20'h00000;
		end else if (wr_bound) begin
			image_bound <= reg_wdata[31:`PELT_PAGE_LSB];
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			image_translation_offset <= 20'h00000;
		end else if (wr_xlat) begin
			image_translation_offset <= reg_wdata[31:`PELT_PAGE_LSB];
		end
	end

	// Read mux; unmapped addresses and reserved bits read as zero.
	always @* begin
		next_rdata = 32'h00000000;
		case (reg_addr)
			`PELT_CMD_LOG_OFF: begin
				next_rdata[`PELT_CMD_LSB +: 4]  = cmd_log;
				next_rdata[`PELT_MULTI_BIT]     = multi_error;
				next_rdata[`PELT_VALID_BIT]     = log_valid;
			end
			`PELT_ADDR_LOG_OFF: begin
				next_rdata = addr_log;
			end
			`PELT_IMG_CTL_OFF: begin
				next_rdata[`PELT_EN_BIT]          = image_enable;
				next_rdata[`PELT_POSTED_BIT]      = posted_write_enable;
				next_rdata[`PELT_WIDTH_LSB +: 2]  = width_sel;
				next_rdata[`PELT_SPACE_LSB +: 3]  = space_sel;
				next_rdata[`PELT_PROGRAM_BIT]     = program_sel;
				next_rdata[`PELT_SUPER_BIT]       = supervisor_sel;
				next_rdata[`PELT_CYCLE_BIT]       = vme_cycle_type;
				next_rdata[`PELT_IOSPACE_BIT]     = pci_space_select;
			end
			`PELT_IMG_BASE_OFF: begin
				next_rdata[31:`PELT_PAGE_LSB] = image_base;
			end
			`PELT_IMG_BOUND_OFF: begin
				next_rdata[31:`PELT_PAGE_LSB] = image_bound;
			end
			`PELT_IMG_XLAT_OFF: begin
				next_rdata[31:`PELT_PAGE_LSB] = image_translation_offset;
			end
			default: begin
				next_rdata = 32'h00000000;
			end
		endcase
	end

	// Read data stand only in the cycle after the read strobe.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_read) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// Window decode on 4 KB pages; a zero bound leaves the window open above the base.
	wire [19:0] page;
	wire [11:0] page_offset;
	wire        above_base;
	wire        bound_open;
	wire        below_bound;
	wire        in_window;
	wire        space_match;
	wire        a24_or_a32;
	wire        width_64;
	wire [20:0] page_sum;
	wire [19:0] vme_page;

	assign page        = pci_address[31:`PELT_PAGE_LSB];
	assign page_offset = pci_address[`PELT_PAGE_LSB-1:0];
	assign above_base  = page >= image_base;
	assign bound_open  = (image_bound == 20'h00000);
	assign below_bound = bound_open || (page < image_bound);
	assign in_window   = above_base && below_bound;
	assign space_match = (pci_io_access == pci_space_select);
	assign image_hit   = image_enable && pci_access && space_match && in_window;

	// An I/O image is always coupled, whatever its posted-write bit holds.
	assign image_posted_write  = posted_write_enable && !pci_space_select;
	assign vme_max_data_width  = width_sel;
	assign vme_address_space   = space_sel;
	assign vme_space_reserved  = (space_sel == `PELT_SPACE_RSV_LO)
		|| (space_sel == `PELT_SPACE_RSV_HI);
	assign program_data_select = program_sel;
	assign supervisor_select   = supervisor_sel;

	// Block transfers need A24 or A32; at 64-bit width the cycle-type bit is ignored.
	assign a24_or_a32 = (space_sel == `PELT_SPACE_A24) || (space_sel == `PELT_SPACE_A32);
	assign width_64   = (width_sel == `PELT_WIDTH_64);
	assign vme_block_transfer = vme_cycle_type && a24_or_a32 && !width_64;
	assign vme_mblt_allowed   = a24_or_a32 && width_64;

	// The carry out of the page sum is dropped, so the offset wraps as two's complement.
	assign page_sum    = {1'b0, page} + {1'b0, image_translation_offset};
	assign vme_page    = page_sum[19:0];
	assign vme_address = {vme_page, page_offset};

endmodule // pelt_top
`default_nettype wire

// ==== bench/pelt_monitor.sv ====
// Assertion checker for the error log and image four control ports.
`timescale 1ns/1ps
`default_nettype none
module pelt_monitor #(
	parameter ADDR_W = 12
) (
	input wire logic		clk,
	input wire logic		reset,
	input wire logic [ADDR_W-1:0]	reg_addr,
	input wire logic [31:0]	reg_wdata,
	input wire logic		reg_write,
	input wire logic		reg_read,
	input wire logic [31:0]	reg_rdata,
	input wire logic		pw_target_abort,
	input wire logic		pw_master_abort,
	input wire logic		pw_retry_expired,
	input wire logic [31:0]	pci_address,
	input wire logic [31:0]	vme_address,
	input wire logic [1:0]	vme_max_data_width,
	input wire logic [2:0]	vme_address_space,
	input wire logic		vme_block_transfer,
	input wire logic		vme_mblt_allowed,
	input wire logic		vme_space_reserved
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire	err = pw_target_abort | pw_master_abort | pw_retry_expired;
	wire	wide = vme_address_space == 3'h1 || vme_address_space == 3'h2;
	wire	log_wr = reg_write && reg_addr == 12'h18C && !err;
	sequence s_evt; err && !reg_write; endsequence
	sequence s_gap; !reg_write && !err; endsequence
	sequence s_rd; reg_read && reg_addr == 12'h18C && !err; endsequence
	property p_valid; s_evt ##1 s_gap ##1 s_rd |=> reg_rdata[23]; endproperty
	a_valid: assert property (p_valid) else $error("log not valid");
	property p_multi; s_evt ##1 s_gap ##1 s_evt ##1 s_gap ##1 s_rd |=> reg_rdata[27]; endproperty
	a_multi: assert property (p_multi) else $error("multi flag low");
	property p_rearm; log_wr && reg_wdata[23] ##1 s_gap ##1 s_rd |=> !reg_rdata[23]; endproperty
	a_rearm: assert property (p_rearm) else $error("rearm failed");
	property p_wr0;
		s_evt ##1 s_gap ##1 log_wr && !reg_wdata[23] ##1 s_gap ##1 s_rd |=> reg_rdata[23];
	endproperty
	a_wr0: assert property (p_wr0) else $error("zero write cleared log");
	property p_blt; vme_block_transfer |-> wide && vme_max_data_width != 2'h3; endproperty
	a_blt: assert property (p_blt) else $error("block transfer out of place");
	property p_mblt; vme_mblt_allowed == (wide && vme_max_data_width == 2'h3); endproperty
	a_mblt: assert property (p_mblt) else $error("mblt flag wrong");
	property p_res; vme_space_reserved == (vme_address_space inside {3'h3, 3'h4}); endproperty
	a_res: assert property (p_res) else $error("reserved flag wrong");
	property p_low; vme_address[11:0] == pci_address[11:0]; endproperty
	a_low: assert property (p_low) else $error("low address bits altered");
endmodule // pelt_monitor
bind pelt_top pelt_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);
`default_nettype wire

// ==== bench/pelt_pci_model.sv ====
// Behavioural PCI master that fails posted writes and presents decode accesses.
`timescale 1ns/1ps
`default_nettype none
module pelt_pci_model (
	input wire logic		clk,
	output var logic		pw_target_abort,
	output var logic		pw_master_abort,
	output var logic		pw_retry_expired,
	output var logic [3:0]	pw_command,
	output var logic [31:0]	pw_start_address,
	output var logic		pci_access,
	output var logic		pci_io_access,
	output var logic [31:0]	pci_address
);
	initial {pw_target_abort, pw_master_abort, pw_retry_expired, pw_command} = '0;
	initial {pw_start_address, pci_access, pci_io_access, pci_address} = '0;
	// Error details go stale once the pulse ends, so they are inverted then.
	task fail(input int k, input logic [3:0] c, input logic [31:0] a);
		@(posedge clk);
		pw_target_abort <= k == 0;
		pw_master_abort <= k == 1;
		pw_retry_expired <= k == 2;
		pw_command <= c;
		pw_start_address <= a;
		@(posedge clk);
		{pw_target_abort, pw_master_abort, pw_retry_expired} <= 3'h0;
		pw_command <= ~c;
		pw_start_address <= ~a;
	endtask
	task access(input logic en, io, input logic [31:0] a);
		@(posedge clk);
		pci_access <= en;
		pci_io_access <= io;
		pci_address <= a;
	endtask
endmodule // pelt_pci_model
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the error log and target image four control.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic		clk = 0;
	logic		reset = 1;
	logic [11:0]	reg_addr = 0;
	logic [31:0]	reg_wdata = 0;
	logic		reg_write = 0;
	logic		reg_read = 0;
	wire [31:0]	reg_rdata, pci_address, vme_address, pw_start_address;
	wire [3:0]	pw_command;
	wire [2:0]	vme_address_space;
	wire [1:0]	vme_max_data_width;
	wire		pw_target_abort, pw_master_abort, pw_retry_expired, pci_access;
	wire		pci_io_access, image_hit, image_posted_write, program_data_select;
	wire		supervisor_select, vme_block_transfer, vme_mblt_allowed, vme_space_reserved;
	integer		fails = 0, n_tests = 0, seed = 80, i;
	logic [31:0]	ma = 0, mctl = 32'h00800000, mbs, mbd, mto, d;
	logic [3:0]	mc = 4'h7;
	logic		mv = 0, mm = 0;
	always #4 clk = ~clk;
	pelt_top dut (.*);
	pelt_pci_model pm (.*);
	task chk(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_write <= 1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_write <= 0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_read <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 0;
		#1 chk(reg_rdata, e);
	endtask
	task err(input int k);
		d = $random(seed);
		pm.fail(k, d[7:4], d);
		mm = mv;
		if (!mv) begin
			mc = d[7:4];
			ma = d;
		end
		mv = 1;
	endtask
	task setc(input logic [31:0] v);
		wr(12'h1A0, v);
		mctl = v & 32'hC0C75101;
	endtask
	task ctl_outs;
		logic [2:0] s;
		logic [1:0] w;
		logic a;
		s = mctl[18:16];
		w = mctl[23:22];
		a = s == 3'h1 || s == 3'h2;
		chk(vme_address_space, s);
		chk(vme_max_data_width, w);
		chk(program_data_select, mctl[14]);
		chk(supervisor_select, mctl[12]);
		chk(vme_block_transfer, mctl[8] && a && w != 2'h3);
		chk(vme_mblt_allowed, a && w == 2'h3);
		chk(vme_space_reserved, s == 3'h3 || s == 3'h4);
		chk(image_posted_write, mctl[30] && !mctl[0]);
	endtask
	function logic [31:0] logw;
		logw = {mc, mm, 3'h0, mv, 23'h0};
	endfunction
	task complete_run;
		if (fails == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		complete_run;
	end
	initial begin
		repeat (8) @(posedge clk);
		reset <= 0;
		rd(12'h18C, logw());
		rd(12'h190, 32'h0);
		rd(12'h1A0, mctl);
		rd(12'h004, 32'h0);
		for (i = 0; i < 3; i++) begin
			err(i);
			rd(12'h18C, logw());
			rd(12'h190, ma);
			err(2 - i);
			wr(12'h18C, 32'h0);
			rd(12'h18C, logw());
			wr(12'h190, $random(seed));
			rd(12'h190, ma);
			err(i);
			err(i);
			rd(12'h18C, logw());
			wr(12'h18C, 32'h00800000);
			mv = 0;
			rd(12'h18C, logw());
		end
		for (i = 0; i < 64; i++) begin
			d = $random(seed);
			d[18:16] = i[2:0];
			d[23:22] = i[4:3];
			d[0] = i[5];
			setc(d);
			rd(12'h1A0, mctl);
			ctl_outs();
		end
		mbs = $random(seed) & 32'h7FFFF000;
		mbd = mbs + 32'h3000;
		mto = $random(seed) & 32'hFFFFF000;
		wr(12'h1A4, mbs | 32'hFFF);
		wr(12'h1A8, mbd);
		wr(12'h1AC, mto);
		rd(12'h1AC, mto);
		setc(32'hC0800000);
		for (i = 0; i < 24; i++) begin
			if (i == 8) setc(32'hC0800001);
			if (i == 12) setc(32'hC0800000);
			if (i == 14) wr(12'h1A8, 32'h0);
			if (i == 14) mbd = 0;
			if (i == 20) setc(32'h00800000);
			d = mbs + (i % 8 - 2) * 32'h1000 + i;
			pm.access(i != 11, i % 8 == 7, d);
			#1 chk(image_hit, i != 11 && mctl[31] && (i % 8 == 7) == mctl[0]
				&& d[31:12] >= mbs[31:12] && (mbd == 0 || d[31:12] < mbd[31:12]));
			chk(vme_address, {d[31:12] + mto[31:12], d[11:0]});
			chk(image_posted_write, mctl[30] && !mctl[0]);
		end
		complete_run;
	end
endmodule // tb
`default_nettype wire
